// File: hw/rpe_pkg.sv
// Constants and carrier types for the RPE grid coder and decoder.
// Assumes one 10 MHz clock and 16-bit two's complement samples.
package rpe_pkg;
	localparam int SEG_LEN = 40;
	localparam int GRID_LEN = 13;
	localparam int NUM_GRID = 4;
	localparam int HIST_LEN = 120;
	localparam int LAR_NUM = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int SAMPLE_W = 16;
	localparam int ENERGY_W = 34;
	localparam int XMAX_EXPS = 6;
	localparam int XMAX_LIN_SHIFT = 5;
	localparam int PULSE_MID = 4;
	localparam int PULSE_LEVELS = 8;
	localparam int NORM_SHIFT = 2;
	localparam int Q15 = 15;
	localparam int INTERP_SHIFT = 2;
	localparam logic [5:0] SEG_LAST = 6'h27;
	localparam logic [5:0] GRID_STEP = 6'h03;
	localparam logic [5:0] GRID_SPAN = 6'h24;
	localparam logic [7:0] SEG_LEN8 = 8'h28;
	localparam logic [7:0] INTERP_B1 = 8'h0D;
	localparam logic [7:0] INTERP_B2 = 8'h1B;
	localparam logic [7:0] INTERP_B3 = 8'h28;
	localparam logic [6:0] LAG_MIN = 7'h01;
	localparam logic [6:0] LAG_MAX = 7'h78;
	localparam logic [15:0] XMAX_KNEE = 16'h0200;
	localparam logic [15:0] XMAX_TOP = 16'h7FFF;
	localparam logic signed [33:0] SAT_MAX = 34'sh0_0000_7FFF;
	localparam logic signed [33:0] SAT_MIN = -34'sh0_0000_8000;
	localparam logic signed [33:0] PULSE_OFF = 34'sh0_0000_0007;
	localparam logic signed [33:0] PULSE_RECON = 34'sh0_0000_1000;
	localparam logic signed [33:0] DEEMPH_BETA = 34'sh0_0000_6E14;
	localparam logic signed [33:0] LAR_B = 34'sh0_0000_0020;
	localparam int LAR_SHIFT = 10;
	localparam logic signed [33:0] R_LIM = 34'sh0_0000_7D00;
	localparam logic signed [15:0] GAIN_QLB [4] = '{
		16'sh0CCD, 16'sh2CCD, 16'sh5333, 16'sh7FFF};

	typedef logic signed [15:0] sample_t;
	typedef struct packed {
		logic [1:0]       grid_code;
		logic [5:0]       xmax_code;
		logic [12:0][2:0] pulse_code;
	} rpe_block_t;
	typedef struct packed {
		logic [7:0][5:0] lar_code;
		logic [6:0]      lag;
		logic [1:0]      gain_code;
		rpe_block_t      rpe;
	} dec_frame_t;
	typedef enum logic [1:0] {
		E_LOAD  = 2'h0,
		E_SEL   = 2'h1,
		E_QUANT = 2'h3,
		E_OUT   = 2'h2
	} enc_state_t;
	typedef enum logic {
		D_IDLE = 1'h0,
		D_RUN  = 1'h1
	} dec_state_t;
endpackage

// File: hw/rpe_codec.sv
// RPE grid selection, APCM coding, RPE decoding, synthesis and de-emphasis.
// Assumes sample streams from logic on CLK_SYS; LAR codes on sub-segment 0.
//
// Functional notes
// (R1) Four grids take every third of 40 samples.
// (R2) Pick grid with largest sum of squares.
// (R3) Emit selected grid as two-bit code.
// (R4) Largest magnitude coded as six-bit maximum.
// (R5) Log table, widths 32 doubling, upper end decoded.
// (R6) Normalize by decoded maximum, not raw.
// (R7) Three-bit uniform pulse code, steps 8192.
// (R8) Pulse code c rebuilds (2c-7)*4096.
// (R9) Denormalize levels with decoded received maximum.
// (R10) Upsample by three, pulses at grid offset.
// (R11) Residual drives long-term then short-term synthesis.
// (R12) Coefficients rebuilt from LAR codes as encoder.
// (R13) De-emphasis adds 28180/32768 of previous output.
// (R14) Upstream supplies forty weighted samples per sub-segment.
// (R15) De-emphasis cleared by reset, output saturates.
// (R16) Equal energies select the lowest grid offset.
`timescale 1ns/1ps
module rpe_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    count;
	logic [AW-1:0]    next_count;
	logic [AW-1:0]    wpos;
	logic             push;
	logic             pop;

	// Head of the queue always sits in slot zero.
	assign in_ready = (count != AW'(DEPTH));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[0];
	assign wpos = pop ? count - 1'b1 : count;

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			out_valid <= 1'b0;
		end else if (ce) begin
			count <= next_count;
			out_valid <= (next_count != '0);
		end
	end

	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem[i] <= '0;
			end else if (ce) begin
				if (push && wpos == AW'(i)) begin
					mem[i] <= in_data;
				end else if (pop) begin
					if (i < DEPTH - 1) begin
						mem[i] <= mem[(i + 1) % DEPTH];
					end else begin
						mem[i] <= '0;
					end
				end
			end
		end
	end
endmodule // rpe_fifo

module rpe_codec (
	input  wire logic                CLK_SYS,
	input  wire logic                RSTN,
	input  wire logic                CE,
	input  wire logic                ENC_IN_VALID,
	input  wire rpe_pkg::sample_t    ENC_IN_DATA,
	output logic                     ENC_IN_READY,
	output rpe_pkg::rpe_block_t      ENC_OUT,
	output logic                     ENC_OUT_VALID,
	input  wire logic                ENC_OUT_READY,
	input  wire logic                DEC_IN_VALID,
	input  wire rpe_pkg::dec_frame_t DEC_IN,
	output logic                     DEC_IN_READY,
	output rpe_pkg::sample_t         DEC_OUT_DATA,
	output logic                     DEC_OUT_VALID,
	input  wire logic                DEC_OUT_READY
);
	function automatic logic in_grid(input logic [1:0] m,
		input logic [5:0] k);
		logic [5:0] d;
		d = k - {4'h0, m};
		in_grid = (k >= {4'h0, m}) && (d % rpe_pkg::GRID_STEP == 6'h00)
			&& (d <= rpe_pkg::GRID_SPAN);
	endfunction

	function automatic logic [5:0] xmax_quant(input logic [15:0] a);
		logic [2:0] e;
		e = 3'h0;
		for (int i = 1; i <= rpe_pkg::XMAX_EXPS; i++) begin
			if (a >= (rpe_pkg::XMAX_KNEE << (i - 1))) e = 3'(i);
		end
		xmax_quant = 6'({10'h000, e, 3'h0}
			+ (a >> (rpe_pkg::XMAX_LIN_SHIFT + int'(e))));
	endfunction

	function automatic logic [15:0] xmax_dec(input logic [5:0] c);
		logic [2:0] e;
		logic [3:0] mant;
		e = (c[5:3] == 3'h0) ? 3'h0 : c[5:3] - 3'h1;
		mant = {(c[5:3] != 3'h0), c[2:0]};
		xmax_dec = (({12'h000, mant} + 16'h0001)
			<< (rpe_pkg::XMAX_LIN_SHIFT + int'(e))) - 16'h0001;
	endfunction

	function automatic rpe_pkg::sample_t sat16(input logic signed [33:0] v);
		if (v > rpe_pkg::SAT_MAX) sat16 = rpe_pkg::SAT_MAX[15:0];
		else if (v < rpe_pkg::SAT_MIN) sat16 = rpe_pkg::SAT_MIN[15:0];
		else sat16 = v[15:0];
	endfunction

	function automatic logic [2:0] pulse_quant(input rpe_pkg::sample_t x,
		input logic [15:0] xd);
		logic signed [19:0] lhs;
		lhs = 20'(x) <<< rpe_pkg::NORM_SHIFT;
		pulse_quant = 3'h0;
		for (int k = 1; k < rpe_pkg::PULSE_LEVELS; k++) begin
			if (lhs >= 20'(k - rpe_pkg::PULSE_MID) * $signed({4'h0, xd}))
				pulse_quant = 3'(k);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Encoder: gather a sub-segment, pick a grid, code it.
	rpe_pkg::enc_state_t         enc_state;
	rpe_pkg::sample_t            seg [rpe_pkg::SEG_LEN];
	logic [rpe_pkg::ENERGY_W-1:0] energy [rpe_pkg::NUM_GRID];
	logic [5:0]                  k_in;
	logic [1:0]                  grid;
	logic [1:0]                  best;
	logic signed [31:0]          sq;
	logic                        enc_take;
	logic [15:0]                 amax;
	logic [5:0]                  xmaxc;
	logic [15:0]                 xd;
	logic [12:0][2:0]            codes;

	assign enc_take = ENC_IN_VALID && ENC_IN_READY;
	assign sq = ENC_IN_DATA * ENC_IN_DATA;

	always_comb begin
		best = 2'h0;
		for (int m = 1; m < rpe_pkg::NUM_GRID; m++) begin
			if (energy[m] > energy[best]) best = 2'(m); // R2 R16
		end
	end

	always_comb begin
		rpe_pkg::sample_t x;
		logic [16:0] a;
		x = '0;
		a = '0;
		amax = '0;
		for (int i = 0; i < rpe_pkg::GRID_LEN; i++) begin
			x = seg[{4'h0, grid} + rpe_pkg::GRID_STEP * 6'(i)]; // R1
			a = x[15] ? 17'(-$signed({x[15], x})) : {1'b0, x};
			if (a > {1'b0, amax}) amax = a[15:0] | {16{a[16]}}; // R4
		end
		if (amax > rpe_pkg::XMAX_TOP) amax = rpe_pkg::XMAX_TOP;
		xmaxc = xmax_quant(amax); // R4 R5
		xd = xmax_dec(xmaxc); // R5 R6
		for (int i = 0; i < rpe_pkg::GRID_LEN; i++) begin
			x = seg[{4'h0, grid} + rpe_pkg::GRID_STEP * 6'(i)];
			codes[i] = pulse_quant(x, xd); // R6 R7
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			enc_state <= rpe_pkg::E_LOAD;
			ENC_IN_READY <= 1'b1;
			k_in <= '0;
		end else if (CE) begin
			case (enc_state)
				rpe_pkg::E_LOAD: begin
					if (enc_take) begin
						k_in <= k_in + 6'h01;
						if (k_in == rpe_pkg::SEG_LAST) begin // R14
							enc_state <= rpe_pkg::E_SEL;
							ENC_IN_READY <= 1'b0;
						end
					end
				end
				rpe_pkg::E_SEL: enc_state <= rpe_pkg::E_QUANT;
				rpe_pkg::E_QUANT: enc_state <= rpe_pkg::E_OUT;
				default: begin
					if (ENC_OUT_READY) begin
						enc_state <= rpe_pkg::E_LOAD;
						ENC_IN_READY <= 1'b1;
						k_in <= '0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < rpe_pkg::SEG_LEN; i++) seg[i] <= '0;
			for (int m = 0; m < rpe_pkg::NUM_GRID; m++) energy[m] <= '0;
		end else if (CE) begin
			if (enc_state == rpe_pkg::E_OUT) begin
				for (int m = 0; m < rpe_pkg::NUM_GRID; m++) energy[m] <= '0;
			end else if (enc_take) begin
				seg[k_in] <= ENC_IN_DATA;
				for (int m = 0; m < rpe_pkg::NUM_GRID; m++) begin
					if (in_grid(2'(m), k_in)) // R1
						energy[m] <= energy[m] + 34'(unsigned'(sq)); // R2
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			grid <= '0;
			ENC_OUT <= '0;
			ENC_OUT_VALID <= 1'b0;
		end else if (CE) begin
			if (enc_state == rpe_pkg::E_SEL) begin
				grid <= best; // R16
			end
			if (enc_state == rpe_pkg::E_QUANT) begin
				ENC_OUT.grid_code <= grid; // R3
				ENC_OUT.xmax_code <= xmaxc; // R4
				ENC_OUT.pulse_code <= codes; // R7
				ENC_OUT_VALID <= 1'b1;
			end else if (enc_state == rpe_pkg::E_OUT && ENC_OUT_READY) begin
				ENC_OUT_VALID <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoder: rebuild residual, synthesize, de-emphasize, queue out.
	rpe_pkg::dec_state_t dec_state;
	rpe_pkg::dec_frame_t hold;
	rpe_pkg::sample_t    lar_prev [rpe_pkg::LAR_NUM];
	rpe_pkg::sample_t    lar_cur [rpe_pkg::LAR_NUM];
	rpe_pkg::sample_t    hist [rpe_pkg::HIST_LEN];
	rpe_pkg::sample_t    lat [rpe_pkg::LAR_NUM];
	rpe_pkg::sample_t    next_lat [rpe_pkg::LAR_NUM];
	rpe_pkg::sample_t    deemph_output;
	rpe_pkg::sample_t    next_d;
	rpe_pkg::sample_t    next_y;
	logic [5:0]          k_dec;
	logic [1:0]          sub;
	logic                fifo_ready;
	logic                dec_step;

	assign dec_step = (dec_state == rpe_pkg::D_RUN) && fifo_ready;

	always_comb begin
		logic signed [33:0] lvl;
		logic signed [33:0] e;
		logic signed [33:0] p;
		logic signed [33:0] c;
		logic signed [33:0] w;
		logic signed [33:0] r;
		logic signed [33:0] s;
		logic [7:0]         kf;
		logic [6:0]         lag;
		logic [2:0]         pc;
		lvl = '0;
		e = '0;
		p = '0;
		c = '0;
		w = '0;
		r = '0;
		kf = 8'(sub) * rpe_pkg::SEG_LEN8 + {2'h0, k_dec};
		lag = hold.lag;
		pc = hold.rpe.pulse_code[4'((k_dec - {4'h0, hold.rpe.grid_code})
			/ rpe_pkg::GRID_STEP)];
		if (in_grid(hold.rpe.grid_code, k_dec)) begin // R10
			lvl = (34'($signed({1'b0, pc, 1'b0})) - rpe_pkg::PULSE_OFF)
				* rpe_pkg::PULSE_RECON; // R8
			e = 34'(sat16((lvl * $signed({18'h00000,
				xmax_dec(hold.rpe.xmax_code)})) >>> rpe_pkg::Q15)); // R9
		end
		if (lag < rpe_pkg::LAG_MIN || lag > rpe_pkg::LAG_MAX)
			lag = rpe_pkg::LAG_MAX;
		next_d = sat16(e + ((34'(rpe_pkg::GAIN_QLB[hold.gain_code])
			* 34'(hist[lag - 7'h01])) >>> rpe_pkg::Q15)); // R11
		s = 34'(next_d);
		next_lat[0] = '0;
		for (int i = rpe_pkg::LAR_NUM - 1; i >= 0; i--) begin
			p = 34'(lar_prev[i]);
			c = 34'(lar_cur[i]);
			if (kf < rpe_pkg::INTERP_B1) w = (3 * p + c) >>> rpe_pkg::INTERP_SHIFT;
			else if (kf < rpe_pkg::INTERP_B2) w = (p + c) >>> 1;
			else if (kf < rpe_pkg::INTERP_B3) w = (p + 3 * c) >>> rpe_pkg::INTERP_SHIFT;
			else w = c; // R12
			r = (w > rpe_pkg::R_LIM) ? rpe_pkg::R_LIM
				: (w < -rpe_pkg::R_LIM) ? -rpe_pkg::R_LIM : w; // R12
			s = 34'(sat16(s - ((r * 34'(lat[i])) >>> rpe_pkg::Q15))); // R11
			if (i < rpe_pkg::LAR_NUM - 1)
				next_lat[(i + 1) % rpe_pkg::LAR_NUM] =
					sat16(34'(lat[i]) + ((r * s) >>> rpe_pkg::Q15));
		end
		next_lat[0] = s[15:0];
		next_y = sat16(s + ((rpe_pkg::DEEMPH_BETA * 34'(deemph_output))
			>>> rpe_pkg::Q15)); // R13 R15
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			dec_state <= rpe_pkg::D_IDLE;
			DEC_IN_READY <= 1'b1;
			hold <= '0;
			k_dec <= '0;
			sub <= '0;
		end else if (CE) begin
			case (dec_state)
				rpe_pkg::D_IDLE: begin
					if (DEC_IN_VALID) begin
						hold <= DEC_IN;
						k_dec <= '0;
						DEC_IN_READY <= 1'b0;
						dec_state <= rpe_pkg::D_RUN;
					end
				end
				default: begin
					if (fifo_ready) begin
						k_dec <= k_dec + 6'h01;
						if (k_dec == rpe_pkg::SEG_LAST) begin
							sub <= sub + 2'h1;
							DEC_IN_READY <= 1'b1;
							dec_state <= rpe_pkg::D_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < rpe_pkg::LAR_NUM; i++) begin
				lar_prev[i] <= '0;
				lar_cur[i] <= '0;
			end
		end else if (CE) begin
			if (dec_state == rpe_pkg::D_IDLE && DEC_IN_VALID && sub == 2'h0) begin
				for (int i = 0; i < rpe_pkg::LAR_NUM; i++) begin
					lar_prev[i] <= lar_cur[i];
					lar_cur[i] <= sat16((34'({28'h0000000, DEC_IN.lar_code[i]})
						- rpe_pkg::LAR_B) <<< rpe_pkg::LAR_SHIFT); // R12
				end
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < rpe_pkg::HIST_LEN; i++) hist[i] <= '0;
			for (int i = 0; i < rpe_pkg::LAR_NUM; i++) lat[i] <= '0;
			deemph_output <= '0; // R15
		end else if (CE && dec_step) begin
			hist[0] <= next_d; // R11
			for (int i = 1; i < rpe_pkg::HIST_LEN; i++) hist[i] <= hist[i - 1];
			for (int i = 0; i < rpe_pkg::LAR_NUM; i++) lat[i] <= next_lat[i];
			deemph_output <= next_y; // R13
		end
	end

	rpe_fifo #(
		.WIDTH (rpe_pkg::SAMPLE_W),
		.DEPTH (rpe_pkg::FIFO_DEPTH)
	) u_out_fifo (
		.clk       (CLK_SYS),
		.rst_n     (RSTN),
		.ce        (CE),
		.in_valid  (dec_state == rpe_pkg::D_RUN),
		.in_data   (next_y),
		.in_ready  (fifo_ready),
		.out_valid (DEC_OUT_VALID),
		.out_data  (DEC_OUT_DATA),
		.out_ready (DEC_OUT_READY)
	);
endmodule // rpe_codec

// File: dv/rpe_upstream.sv
// Upstream weighting stage model: forty samples per sub-segment.
// Assumes the encoder input handshake on the same clock.
`timescale 1ns/1ps
module rpe_upstream (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic             slow,
	input  wire logic             ready,
	input  wire rpe_pkg::sample_t smp [40],
	output logic                  valid,
	output rpe_pkg::sample_t      data
);
	int   idx = 40;
	logic took = 1'b0;
	logic gap;
	initial valid = 1'b0;
	initial data = '0;
	always @(posedge clk) took <= valid && ready;
	always @(negedge clk or negedge rst_n) begin
		gap = 1'b0;
		if (!rst_n) idx = 40;
		else if (took) begin
			idx = idx + 1;
			gap = slow;
		end
		if (start) idx = 0;
		if (idx < 40 && !gap) begin
			valid = 1'b1;
			data = smp[idx];
		end else begin
			valid = 1'b0;
			data = ~data;
		end
	end
endmodule // rpe_upstream

// File: dv/rpe_codec_asserts.sv
// Port checker for the grid coder and decoder.
// Assumes one clock and an active low asynchronous reset.
`timescale 1ns/1ps
module rpe_codec_asserts (
	input wire logic                CLK_SYS,
	input wire logic                RSTN,
	input wire logic                CE,
	input wire logic                ENC_IN_VALID,
	input wire logic                ENC_IN_READY,
	input wire rpe_pkg::rpe_block_t ENC_OUT,
	input wire logic                ENC_OUT_VALID,
	input wire logic                ENC_OUT_READY,
	input wire logic                DEC_IN_VALID,
	input wire logic                DEC_IN_READY,
	input wire rpe_pkg::sample_t    DEC_OUT_DATA,
	input wire logic                DEC_OUT_VALID,
	input wire logic                DEC_OUT_READY
);
	logic [5:0] takes;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) takes <= 6'h00;
		else if (CE && ENC_IN_VALID && ENC_IN_READY)
			takes <= (takes == 6'h27) ? 6'h00 : takes + 6'h01;
	end
	sequence s_last_take;
		CE && ENC_IN_VALID && ENC_IN_READY && takes == 6'h27;
	endsequence
	sequence s_dec_take;
		CE && DEC_IN_VALID && DEC_IN_READY;
	endsequence
	sequence s_enc_wait;
		!ENC_OUT_VALID ##1 !ENC_OUT_VALID;
	endsequence
	a_enc_ready_drop: assert property (s_last_take |=> !ENC_IN_READY)
		else $error("input ready after last sample");
	a_enc_out_lat: assert property (
		s_last_take |=> s_enc_wait ##[1:2] ENC_OUT_VALID)
		else $error("coded block latency wrong");
	a_enc_hold: assert property (ENC_OUT_VALID && !ENC_OUT_READY |=>
		ENC_OUT_VALID && $stable(ENC_OUT))
		else $error("coded block not held");
	a_enc_release: assert property (CE && ENC_OUT_VALID && ENC_OUT_READY
		|=> !ENC_OUT_VALID ##[0:1] ENC_IN_READY)
		else $error("coded block not released");
	a_dec_busy: assert property (s_dec_take |=> !DEC_IN_READY [*8])
		else $error("decoder ready too soon");
	a_dec_first_out: assert property (
		s_dec_take ##0 !DEC_OUT_VALID |-> ##[1:3] DEC_OUT_VALID)
		else $error("first decoded sample late");
	a_dec_hold: assert property (DEC_OUT_VALID && !DEC_OUT_READY |=>
		DEC_OUT_VALID && $stable(DEC_OUT_DATA))
		else $error("decoded sample not held");
	a_reset_clear: assert property (disable iff (1'b0) !RSTN |->
		!ENC_OUT_VALID && !DEC_OUT_VALID && DEC_OUT_DATA == 16'sh0000)
		else $error("outputs not cleared in reset");
endmodule // rpe_codec_asserts

bind rpe_codec rpe_codec_asserts chk (.CLK_SYS, .RSTN, .CE, .ENC_IN_VALID,
	.ENC_IN_READY, .ENC_OUT, .ENC_OUT_VALID, .ENC_OUT_READY, .DEC_IN_VALID,
	.DEC_IN_READY, .DEC_OUT_DATA, .DEC_OUT_VALID, .DEC_OUT_READY);

// File: dv/test_rpe_codec.sv
// Self-checking bench for the grid coder and decoder.
// Assumes the upstream model and the bound port checker.
`timescale 1ns/1ps
module test_rpe_codec;
	logic                CLK_SYS = 1'b0;
	logic                RSTN = 1'b1;
	logic                CE = 1'b1;
	logic                ENC_IN_VALID;
	rpe_pkg::sample_t    ENC_IN_DATA;
	logic                ENC_IN_READY;
	rpe_pkg::rpe_block_t ENC_OUT;
	logic                ENC_OUT_VALID;
	logic                ENC_OUT_READY = 1'b0;
	logic                DEC_IN_VALID = 1'b0;
	rpe_pkg::dec_frame_t DEC_IN = '0;
	logic                DEC_IN_READY;
	rpe_pkg::sample_t    DEC_OUT_DATA;
	logic                DEC_OUT_VALID;
	logic                DEC_OUT_READY = 1'b0;
	logic                start = 1'b0;
	logic                slow = 1'b0;
	rpe_pkg::sample_t    smp [40];
	int                  fail_count = 0;
	int                  cmp_count = 0;

	always #50 CLK_SYS = ~CLK_SYS;

	rpe_codec dut (.CLK_SYS, .RSTN, .CE, .ENC_IN_VALID, .ENC_IN_DATA,
		.ENC_IN_READY, .ENC_OUT, .ENC_OUT_VALID, .ENC_OUT_READY, .DEC_IN_VALID,
		.DEC_IN, .DEC_IN_READY, .DEC_OUT_DATA, .DEC_OUT_VALID, .DEC_OUT_READY);
	rpe_upstream up (.clk(CLK_SYS), .rst_n(RSTN), .start, .slow,
		.ready(ENC_IN_READY), .smp, .valid(ENC_IN_VALID), .data(ENC_IN_DATA));

	task automatic fail(input string m);
		fail_count++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask
	task automatic cmp_blk(input rpe_pkg::rpe_block_t g, e, input string m);
		cmp_count++;
		if (g !== e) fail(m);
	endtask
	task automatic cmp_smp(input rpe_pkg::sample_t g, e, input string m);
		cmp_count++;
		if (g !== e) fail(m);
	endtask
	task automatic cmp_flag(input logic g, e, input string m);
		cmp_count++;
		if (g !== e) fail(m);
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	function automatic int xdec(input int c);
		int b = 512;
		int w = 64;
		int n = c - 16;
		if (c < 16) return 32 * c + 31;
		while (n >= 8) begin
			b += 8 * w;
			w *= 2;
			n -= 8;
		end
		return b + (n + 1) * w - 1;
	endfunction
	function automatic rpe_pkg::rpe_block_t enc_ref();
		rpe_pkg::rpe_block_t r = '0;
		longint e;
		longint best = -1;
		int mx = 0;
		int v;
		int xd;
		for (int m = 0; m < 4; m++) begin
			e = 0;
			for (int i = 0; i < 13; i++) e += longint'(smp[m+3*i]) ** 2;
			if (e > best) begin
				best = e;
				r.grid_code = 2'(m);
			end
		end
		for (int i = 0; i < 13; i++) begin
			v = smp[r.grid_code+3*i];
			if (v < 0) v = -v;
			if (v > mx) mx = v;
		end
		if (mx > 32767) mx = 32767;
		r.xmax_code = 6'h3F;
		for (int c = 62; c >= 0; c--) if (mx <= xdec(c)) r.xmax_code = 6'(c);
		xd = xdec(r.xmax_code);
		for (int i = 0; i < 13; i++) begin
			v = smp[r.grid_code+3*i];
			for (int k = 1; k < 8; k++)
				if (4 * v >= (k - 4) * xd) r.pulse_code[i] = 3'(k);
		end
		return r;
	endfunction

	task automatic run_enc(input logic s);
		rpe_pkg::rpe_block_t exp;
		int n = 0;
		exp = enc_ref();
		slow <= s;
		start <= 1'b1;
		@(negedge CLK_SYS);
		start <= 1'b0;
		while (ENC_OUT_VALID !== 1'b1 && n < 300) begin
			@(negedge CLK_SYS);
			n++;
		end
		if (n == 300) begin
			fail("encoder timeout");
			close_out();
		end
		cmp_flag(ENC_IN_READY, 1'b0, "input open");
		cmp_blk(ENC_OUT, exp, "coded block");
		ENC_OUT_READY = 1'b1;
		@(negedge CLK_SYS);
		ENC_OUT_READY = 1'b0;
	endtask
	task automatic scn_tie;
		for (int k = 0; k < 40; k++)
			smp[k] = (k % 3 == 0) ? 16'sh0000 :
				16'((k % 3 == 1 ? 1 : -1) * ((k / 3) * 700 - 4000));
		run_enc(1'b0);
	endtask
	task automatic scn_clamp;
		for (int k = 0; k < 40; k++)
			smp[k] = (k % 3 == 0 && k > 0) ? 16'(k == 39 ? -32768 : k * 500) : 1;
		run_enc(1'b1);
	endtask
	task automatic scn_knee_reset;
		for (int k = 0; k < 40; k++)
			smp[k] = (k == 38) ? 512 : 16'(k % 3 == 2 ? -511 : 31);
		start <= 1'b1;
		@(negedge CLK_SYS);
		start <= 1'b0;
		repeat (10) @(negedge CLK_SYS);
		RSTN = 1'b0;
		@(negedge CLK_SYS);
		cmp_flag(ENC_IN_READY, 1'b1, "ready in reset");
		RSTN = 1'b1;
		run_enc(1'b0);
	endtask
	task automatic scn_dec(input logic [6:0] lag, input logic [1:0] gain);
		rpe_pkg::sample_t exp [40];
		int d [40];
		int y = 0;
		int p;
		int n = 0;
		int got = 0;
		for (int k = 0; k < 40; k++) begin
			p = 0;
			if (k % 3 == 1 && k < 38) p = ((2 * (k / 3 % 8) - 7) * 4096 * 32767) >>> 15;
			if (k >= lag) p += (rpe_pkg::GAIN_QLB[gain] * d[k - lag]) >>> 15;
			d[k] = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
			y = d[k] + ((28180 * y) >>> 15);
			y = y > 32767 ? 32767 : (y < -32768 ? -32768 : y);
			exp[k] = 16'(y);
		end
		DEC_IN.lar_code = {8{6'h20}};
		DEC_IN.lag = lag;
		DEC_IN.gain_code = gain;
		DEC_IN.rpe.grid_code = 2'h1;
		DEC_IN.rpe.xmax_code = 6'h3F;
		for (int i = 0; i < 13; i++) DEC_IN.rpe.pulse_code[i] = 3'(i % 8);
		DEC_IN_VALID = 1'b1;
		@(negedge CLK_SYS);
		DEC_IN_VALID = 1'b0;
		repeat (60) @(negedge CLK_SYS);
		cmp_flag(DEC_IN_READY, 1'b0, "ran past full buffer");
		while (got < 40 && n < 400) begin
			DEC_OUT_READY = n[0];
			CE = (n % 5 != 3);
			if (n[0] && CE && DEC_OUT_VALID === 1'b1) begin
				cmp_smp(DEC_OUT_DATA, exp[got], "decoded sample");
				got++;
			end
			@(negedge CLK_SYS);
			n++;
		end
		DEC_OUT_READY = 1'b0;
		CE = 1'b1;
		if (got < 40) begin
			fail("decoder timeout");
			close_out();
		end
		repeat (4) @(negedge CLK_SYS);
		cmp_flag(DEC_OUT_VALID, 1'b0, "extra samples");
	endtask

	initial begin
		for (int k = 0; k < 40; k++) smp[k] = '0;
		#1 RSTN = 1'b0;
		repeat (8) @(negedge CLK_SYS);
		RSTN = 1'b1;
		@(negedge CLK_SYS);
		scn_dec(7'h78, 2'h0);
		scn_tie();
		scn_clamp();
		scn_knee_reset();
		scn_dec(7'h05, 2'h2);
		close_out();
	end
endmodule // test_rpe_codec
